// ==== inc/ars_pkg.sv ====
// ars_pkg: constants and carrier types for the architectural register set
// assumes: one core clock, software reaches the bank only through msr ops
package ars_pkg;

  // ----------------------------------------------------------------------
  // msr indices
  // ----------------------------------------------------------------------
  localparam logic [31:0] IDX_MC_FAULT_ADDR_LOG = 32'h0000_0000;
  localparam logic [31:0] IDX_MC_FAULT_KIND_LOG = 32'h0000_0001;
  localparam logic [31:0] IDX_L1_CACHE_TEST_CTL = 32'h0000_000E;
  localparam logic [31:0] IDX_CYCLE_TALLY       = 32'h0000_0010;
  localparam logic [31:0] IDX_EXT_FEATURE_CTL   = 32'hC000_0080;
  localparam logic [31:0] IDX_SYSCALL_TARGET    = 32'hC000_0081;
  localparam logic [31:0] IDX_WRITE_ALLOC_CTL   = 32'hC000_0082;
  localparam logic [31:0] IDX_UC_WC_RANGE_CTL   = 32'hC000_0085;
  localparam logic [31:0] IDX_POWER_MGMT_CTL    = 32'hC000_0086;
  localparam logic [31:0] IDX_CPU_STATE_VIEW    = 32'hC000_0087;
  localparam logic [31:0] IDX_PAGE_FLUSH_CTL    = 32'hC000_0088;
  localparam logic [31:0] IDX_L2_ARRAY_PORT     = 32'hC000_0089;

  // ----------------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------------
  localparam int          NUM_MSR       = 12;
  localparam int          NUM_GPR       = 8;
  localparam int          NUM_SEG       = 6;
  localparam int          NUM_FP        = 8;
  localparam int          NUM_DBG       = 8;
  localparam int          NUM_CR        = 5;
  localparam logic [63:0] MSR_RST       = 64'h0000_0000_0000_0000;
  localparam logic [63:0] TALLY_STEP    = 64'h0000_0000_0000_0001;
  localparam logic [15:0] FP_CTRL_RST   = 16'h037F;
  localparam logic [15:0] FP_TAG_RST    = 16'hFFFF;
  localparam logic [31:0] FLAG_RST      = 32'h0000_0002;
  localparam logic [31:0] FLAG_WR_MASK  = 32'h0000_0FD5;
  localparam int          FLAG_DIR_BIT  = 10;
  localparam int          CR0_PE_BIT    = 0;
  localparam int          CR4_MCE_BIT   = 6;

  // ----------------------------------------------------------------------
  // slot numbers of the msr bank
  // ----------------------------------------------------------------------
  localparam logic [3:0] SL_MCA  = 4'h0;
  localparam logic [3:0] SL_MCT  = 4'h1;
  localparam logic [3:0] SL_L1T  = 4'h2;
  localparam logic [3:0] SL_TAL  = 4'h3;
  localparam logic [3:0] SL_EFC  = 4'h4;
  localparam logic [3:0] SL_SYS  = 4'h5;
  localparam logic [3:0] SL_WAC  = 4'h6;
  localparam logic [3:0] SL_UWC  = 4'h7;
  localparam logic [3:0] SL_PWR  = 4'h8;
  localparam logic [3:0] SL_CSV  = 4'h9;
  localparam logic [3:0] SL_PFC  = 4'hA;
  localparam logic [3:0] SL_L2A  = 4'hB;
  localparam logic [3:0] SL_NONE = 4'hF;

  // register file targets for plain writes
  typedef enum logic [2:0] {
    ARS_TGT_GPR,
    ARS_TGT_SEG,
    ARS_TGT_FP,
    ARS_TGT_FPW,
    ARS_TGT_FLAG,
    ARS_TGT_CR,
    ARS_TGT_DBG
  } ars_tgt_t;

  // operand sizes of a general-purpose access
  typedef enum logic [2:0] {
    ARS_SZ_BYTE_LO,
    ARS_SZ_BYTE_HI,
    ARS_SZ_WORD,
    ARS_SZ_DWORD,
    ARS_SZ_QWORD
  } ars_size_t;

  typedef struct packed {
    logic      wr;
    ars_tgt_t  tgt;
    logic [2:0] sel;
    ars_size_t size;
    logic [1:0] sub;
    logic [63:0] data;
  } ars_wr_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] index;
    logic [31:0] lo;
    logic [31:0] hi;
  } ars_msr_req_t;

  typedef struct packed {
    logic        done;
    logic        gp_fault;
    logic [31:0] lo;
    logic [31:0] hi;
  } ars_msr_rsp_t;

endpackage : ars_pkg

// ==== core/ars_regset.sv ====
// ars_regset: architectural register storage and model-specific bank
// assumes: execute stage drives plain writes and msr ops, one per cycle
//
// How it works
// - gpr operands as byte, word, dword, qword
// - six 16-bit segment selectors
// - selector gives real base or descriptor index
// - pointer changes only via transfer targets
// - eight 80-bit floating-point stack registers
// - fp status, control and tag words
// - simd registers alias fp stack mantissas
// - simd read as packed single reals
// - flags hold system, direction, status groups
// - five control and 32-bit debug registers
// - eleven msrs, twelve on low-power parts
// - counter gpr index selects the msr
// - msr value split over accumulator, data
// - low indices 00h 01h 0Eh 10h
// - extended indices C000_0080h to C000_0082h
// - extended indices C000_0085h to C000_0089h
// - machine-check exception is never raised
// - both machine-check logs are 64 bits
// - logs change only by write or reset
// - eight 32-bit gprs, four byte-split
// - cycle tally increments every clock it is not written
`timescale 1ns/1ps

module ars_regset #(
  parameter bit LOW_POWER = 1'b0
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  input  wire ars_pkg::ars_wr_t      wr_i,
  input  wire logic                  ip_load_i,
  input  wire logic [31:0]           ip_target_i,
  input  wire logic                  ip_wide_i,
  input  wire ars_pkg::ars_msr_req_t msr_i,
  input  wire logic [2:0]            rd_sel_i,
  output logic [31:0]                gpr_rd_o,
  output logic [15:0]                seg_rd_o,
  output logic [63:0]                simd_rd_o,
  output logic [31:0]                instr_pointer_wide_o,
  output logic [31:0]                flag_word_o,
  output logic                       protected_mode_o,
  output logic                       mc_exception_o,
  output ars_pkg::ars_msr_rsp_t      msr_o
);

  // ----------------------------------------------------------------------
  // index decode
  // ----------------------------------------------------------------------
  function automatic logic [3:0] slot_of(input logic [31:0] idx, input bit lp);
    case (idx)
      ars_pkg::IDX_MC_FAULT_ADDR_LOG: slot_of = ars_pkg::SL_MCA;
      ars_pkg::IDX_MC_FAULT_KIND_LOG: slot_of = ars_pkg::SL_MCT;
      ars_pkg::IDX_L1_CACHE_TEST_CTL: slot_of = ars_pkg::SL_L1T;
      ars_pkg::IDX_CYCLE_TALLY:       slot_of = ars_pkg::SL_TAL;
      ars_pkg::IDX_EXT_FEATURE_CTL:   slot_of = ars_pkg::SL_EFC;
      ars_pkg::IDX_SYSCALL_TARGET:    slot_of = ars_pkg::SL_SYS;
      ars_pkg::IDX_WRITE_ALLOC_CTL:   slot_of = ars_pkg::SL_WAC;
      ars_pkg::IDX_UC_WC_RANGE_CTL:   slot_of = ars_pkg::SL_UWC;
      ars_pkg::IDX_POWER_MGMT_CTL:    slot_of = lp ? ars_pkg::SL_PWR : ars_pkg::SL_NONE;
      ars_pkg::IDX_CPU_STATE_VIEW:    slot_of = ars_pkg::SL_CSV;
      ars_pkg::IDX_PAGE_FLUSH_CTL:    slot_of = ars_pkg::SL_PFC;
      ars_pkg::IDX_L2_ARRAY_PORT:     slot_of = ars_pkg::SL_L2A;
      default:                        slot_of = ars_pkg::SL_NONE;
    endcase
  endfunction : slot_of

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [31:0] gpr_q  [ars_pkg::NUM_GPR];
  logic [15:0] seg_q  [ars_pkg::NUM_SEG];
  logic [79:0] fp_q   [ars_pkg::NUM_FP];
  logic [15:0] fp_stat_q;
  logic [15:0] fp_ctrl_q;
  logic [15:0] fp_tag_q;
  logic [31:0] flag_q;
  logic [31:0] cr_q   [ars_pkg::NUM_CR];
  logic [31:0] dbg_q  [ars_pkg::NUM_DBG];
  logic [31:0] ip_q;
  logic [63:0] msr_q  [ars_pkg::NUM_MSR];

  logic [3:0]  slot;
  logic        hit;
  logic        msr_wr;
  logic [2:0]  qw_next;

  assign slot   = slot_of(msr_i.index, LOW_POWER);
  assign hit    = (slot != ars_pkg::SL_NONE);
  assign msr_wr = msr_i.wr && hit;
  // quadword high half lands in the next register; 7 wraps to 0
  assign qw_next = 3'(wr_i.sel + 3'h1);

  // ----------------------------------------------------------------------
  // general-purpose registers
  // ----------------------------------------------------------------------
  // eight 32-bit, low four byte split
  genvar g;
  generate
    for (g = 0; g < ars_pkg::NUM_GPR; g++) begin : g_gpr
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          gpr_q[g] <= 32'h0000_0000;
        end else if (wr_i.wr && wr_i.tgt == ars_pkg::ARS_TGT_GPR && wr_i.sel == g) begin
          case (wr_i.size)
            ars_pkg::ARS_SZ_BYTE_LO: begin
              if (g < 4) gpr_q[g][7:0] <= wr_i.data[7:0];
            end
            ars_pkg::ARS_SZ_BYTE_HI: begin
              if (g < 4) gpr_q[g][15:8] <= wr_i.data[7:0];
            end
            ars_pkg::ARS_SZ_WORD:  gpr_q[g][15:0] <= wr_i.data[15:0];
            ars_pkg::ARS_SZ_DWORD: gpr_q[g] <= wr_i.data[31:0];
            // quadword spans the register and the next one, 7 wrapping to 0
            ars_pkg::ARS_SZ_QWORD: gpr_q[g] <= wr_i.data[31:0];
            default: gpr_q[g] <= gpr_q[g];
          endcase
        end else if (wr_i.wr && wr_i.tgt == ars_pkg::ARS_TGT_GPR
                     && wr_i.size == ars_pkg::ARS_SZ_QWORD && qw_next == 3'(g)) begin
          gpr_q[g] <= wr_i.data[63:32];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // segments, pointer, flags
  // ----------------------------------------------------------------------
  // six 16-bit selectors
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < ars_pkg::NUM_SEG; i++) seg_q[i] <= 16'h0000;
    end else if (wr_i.wr && wr_i.tgt == ars_pkg::ARS_TGT_SEG
                 && wr_i.sel < 3'(ars_pkg::NUM_SEG)) begin
      seg_q[wr_i.sel] <= wr_i.data[15:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ip_q <= 32'h0000_0000;
    end else if (ip_load_i) begin
      ip_q <= ip_wide_i ? ip_target_i : {16'h0000, ip_target_i[15:0]};
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_q <= ars_pkg::FLAG_RST;
    end else if (wr_i.wr && wr_i.tgt == ars_pkg::ARS_TGT_FLAG) begin
      flag_q <= (wr_i.data[31:0] & ars_pkg::FLAG_WR_MASK) | ars_pkg::FLAG_RST;
    end
  end

  // ----------------------------------------------------------------------
  // floating point and simd
  // ----------------------------------------------------------------------
  // eight 80-bit stack entries
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < ars_pkg::NUM_FP; i++) fp_q[i] <= 80'h0;
    end else if (wr_i.wr && wr_i.tgt == ars_pkg::ARS_TGT_FP) begin
      if (wr_i.size == ars_pkg::ARS_SZ_QWORD) begin
        // simd write sets exponent to all ones, as the fp stack expects
        fp_q[wr_i.sel] <= {16'hFFFF, wr_i.data};
      end else begin
        fp_q[wr_i.sel][63:0] <= wr_i.data;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fp_stat_q <= 16'h0000;
      fp_ctrl_q <= ars_pkg::FP_CTRL_RST;
      fp_tag_q  <= ars_pkg::FP_TAG_RST;
    end else if (wr_i.wr && wr_i.tgt == ars_pkg::ARS_TGT_FPW) begin
      case (wr_i.sub)
        2'h0:    fp_stat_q <= wr_i.data[15:0];
        2'h1:    fp_ctrl_q <= wr_i.data[15:0];
        2'h2:    fp_tag_q  <= wr_i.data[15:0];
        default: fp_tag_q  <= fp_tag_q;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // control and debug
  // ----------------------------------------------------------------------
  // five control, eight debug
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < ars_pkg::NUM_CR; i++) cr_q[i] <= 32'h0000_0000;
    end else if (wr_i.wr && wr_i.tgt == ars_pkg::ARS_TGT_CR
                 && wr_i.sel < 3'(ars_pkg::NUM_CR)) begin
      cr_q[wr_i.sel] <= wr_i.data[31:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < ars_pkg::NUM_DBG; i++) dbg_q[i] <= 32'h0000_0000;
    end else if (wr_i.wr && wr_i.tgt == ars_pkg::ARS_TGT_DBG) begin
      dbg_q[wr_i.sel] <= wr_i.data[31:0];
    end
  end

  // ----------------------------------------------------------------------
  // model-specific bank
  // ----------------------------------------------------------------------
  // index picks the slot
  // tally counts every clock; a write replaces the count
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < ars_pkg::NUM_MSR; i++) msr_q[i] <= ars_pkg::MSR_RST;
    end else begin
      for (int i = 0; i < ars_pkg::NUM_MSR; i++) begin
        if (msr_wr && slot == 4'(i)) begin
          msr_q[i] <= {msr_i.hi, msr_i.lo};
        end else if (4'(i) == ars_pkg::SL_TAL) begin
          msr_q[i] <= msr_q[i] + ars_pkg::TALLY_STEP;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // read splits over two halves
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      msr_o <= '0;
    end else begin
      msr_o.done     <= msr_i.rd || msr_i.wr;
      msr_o.gp_fault <= (msr_i.rd || msr_i.wr) && !hit;
      msr_o.lo       <= (msr_i.rd && hit) ? msr_q[slot][31:0]  : 32'h0000_0000;
      msr_o.hi       <= (msr_i.rd && hit) ? msr_q[slot][63:32] : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gpr_rd_o             <= 32'h0000_0000;
      seg_rd_o             <= 16'h0000;
      simd_rd_o            <= 64'h0;
      instr_pointer_wide_o <= 32'h0000_0000;
      flag_word_o          <= 32'h0000_0000;
      protected_mode_o     <= 1'b0;
      mc_exception_o       <= 1'b0;
    end else begin
      gpr_rd_o             <= gpr_q[rd_sel_i];
      seg_rd_o             <= (rd_sel_i < 3'(ars_pkg::NUM_SEG)) ? seg_q[rd_sel_i] : 16'h0000;
      // two packed singles, high and low
      simd_rd_o            <= fp_q[rd_sel_i][63:0];
      instr_pointer_wide_o <= ip_q;
      flag_word_o          <= flag_q;
      // mode picks base or descriptor use
      protected_mode_o     <= cr_q[0][ars_pkg::CR0_PE_BIT];
      mc_exception_o       <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_miss_faults;
    @(posedge ref_clk_i) disable iff (rst_i)
    (msr_i.rd || msr_i.wr) && !hit |=> msr_o.gp_fault && msr_o.done;
  endproperty
  a_miss_faults: assert property (p_miss_faults) else $error("miss did not fault");

  property p_tally_counts;
    @(posedge ref_clk_i) disable iff (rst_i)
    !(msr_wr && slot == ars_pkg::SL_TAL) |=>
      msr_q[ars_pkg::SL_TAL] == $past(msr_q[ars_pkg::SL_TAL]) + ars_pkg::TALLY_STEP;
  endproperty
  a_tally_counts: assert property (p_tally_counts) else $error("tally missed a step");

  property p_log_holds;
    @(posedge ref_clk_i) disable iff (rst_i)
    !(msr_wr && slot == ars_pkg::SL_MCA) |=> $stable(msr_q[ars_pkg::SL_MCA]);
  endproperty
  a_log_holds: assert property (p_log_holds) else $error("address log moved");

  property p_kind_write;
    @(posedge ref_clk_i) disable iff (rst_i)
    msr_i.wr && msr_i.index == ars_pkg::IDX_MC_FAULT_KIND_LOG |=>
      msr_q[ars_pkg::SL_MCT] == {$past(msr_i.hi), $past(msr_i.lo)};
  endproperty
  a_kind_write: assert property (p_kind_write) else $error("kind log not written");

  sequence s_rd_hit;
    msr_i.rd && hit && !msr_i.wr && slot != ars_pkg::SL_TAL;
  endsequence
  property p_read_value;
    @(posedge ref_clk_i) disable iff (rst_i)
    s_rd_hit |=> {msr_o.hi, msr_o.lo} == $past(msr_q[slot]) && !msr_o.gp_fault;
  endproperty
  a_read_value: assert property (p_read_value) else $error("read value wrong");

  property p_power_gated;
    @(posedge ref_clk_i) disable iff (rst_i)
    msr_i.rd && msr_i.index == ars_pkg::IDX_POWER_MGMT_CTL |=> msr_o.gp_fault == !LOW_POWER;
  endproperty
  a_power_gated: assert property (p_power_gated) else $error("power index gating wrong");

  property p_no_mc;
    @(posedge ref_clk_i) disable iff (rst_i)
    cr_q[4][ars_pkg::CR4_MCE_BIT] |=> !mc_exception_o;
  endproperty
  a_no_mc: assert property (p_no_mc) else $error("machine check raised");

  property p_ip_only_load;
    @(posedge ref_clk_i) disable iff (rst_i)
    !ip_load_i |=> $stable(ip_q);
  endproperty
  a_ip_only_load: assert property (p_ip_only_load) else $error("pointer changed");

  property p_ctl_holds;
    @(posedge ref_clk_i) disable iff (rst_i)
    !(msr_wr && slot == ars_pkg::SL_EFC) |=> $stable(msr_q[ars_pkg::SL_EFC]);
  endproperty
  a_ctl_holds: assert property (p_ctl_holds) else $error("feature control moved");

  sequence s_qword_wr;
    wr_i.wr && wr_i.tgt == ars_pkg::ARS_TGT_GPR && wr_i.size == ars_pkg::ARS_SZ_QWORD;
  endsequence
  property p_qword_wrap;
    @(posedge ref_clk_i) disable iff (rst_i)
    s_qword_wr |=> gpr_q[$past(qw_next)] == $past(wr_i.data[63:32]);
  endproperty
  a_qword_wrap: assert property (p_qword_wrap) else $error("qword high half lost");

  property p_ip_narrow;
    @(posedge ref_clk_i) disable iff (rst_i)
    ip_load_i && !ip_wide_i |=> ip_q == {16'h0000, $past(ip_target_i[15:0])};
  endproperty
  a_ip_narrow: assert property (p_ip_narrow) else $error("narrow pointer wrong");

  property p_fp_status;
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_i.wr && wr_i.tgt == ars_pkg::ARS_TGT_FPW && wr_i.sub == 2'h0 |=>
      fp_stat_q == $past(wr_i.data[15:0]);
  endproperty
  a_fp_status: assert property (p_fp_status) else $error("fp status not written");

  property p_miss_no_data;
    @(posedge ref_clk_i) disable iff (rst_i)
    (msr_i.rd || msr_i.wr) && !hit |=>
      msr_o.lo == 32'h0000_0000 && msr_o.hi == 32'h0000_0000;
  endproperty
  a_miss_no_data: assert property (p_miss_no_data) else $error("miss returned data");

  property p_simd_write;
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_i.wr && wr_i.tgt == ars_pkg::ARS_TGT_FP && wr_i.size == ars_pkg::ARS_SZ_QWORD |=>
      fp_q[$past(wr_i.sel)] == {16'hFFFF, $past(wr_i.data)};
  endproperty
  a_simd_write: assert property (p_simd_write) else $error("simd write lost");

endmodule : ars_regset

// ==== tb/ars_testbench.sv ====
// testbench: self-checking bench for the architectural register set
// assumes: ars_pkg compiled first, one low-power instance, 200 MHz core clock
`timescale 1ns/1ps

module testbench;

  logic                  ref_clk_i;
  logic                  rst_i;
  ars_pkg::ars_wr_t      wr_i;
  logic                  ip_load_i;
  logic [31:0]           ip_target_i;
  logic                  ip_wide_i;
  ars_pkg::ars_msr_req_t msr_i;
  logic [2:0]            rd_sel_i;
  logic [31:0]           gpr_rd_o;
  logic [15:0]           seg_rd_o;
  logic [63:0]           simd_rd_o;
  logic [31:0]           instr_pointer_wide_o;
  logic [31:0]           flag_word_o;
  logic                  protected_mode_o;
  logic                  mc_exception_o;
  ars_pkg::ars_msr_rsp_t msr_o;
  int                    num_errors;
  int                    total_checks;
  logic [63:0]           d;
  logic                  f;
  logic [63:0]           tq[$];
  logic [31:0]           idx_tab[11];

  ars_regset #(.LOW_POWER(1'b1)) ars_regset_i (
    .ref_clk_i            (ref_clk_i),
    .rst_i                (rst_i),
    .wr_i                 (wr_i),
    .ip_load_i            (ip_load_i),
    .ip_target_i          (ip_target_i),
    .ip_wide_i            (ip_wide_i),
    .msr_i                (msr_i),
    .rd_sel_i             (rd_sel_i),
    .gpr_rd_o             (gpr_rd_o),
    .seg_rd_o             (seg_rd_o),
    .simd_rd_o            (simd_rd_o),
    .instr_pointer_wide_o (instr_pointer_wide_o),
    .flag_word_o          (flag_word_o),
    .protected_mode_o     (protected_mode_o),
    .mc_exception_o       (mc_exception_o),
    .msr_o                (msr_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic do_reset;
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask : do_reset

  // request held for exactly one taking edge, answer waited for under a bound
  task automatic msr_op(input logic rd, input logic wr, input logic [31:0] idx,
                        input logic [63:0] val, output logic [63:0] data, output logic flt);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    msr_i <= '{rd: rd, wr: wr, index: idx, lo: val[31:0], hi: val[63:32]};
    @(posedge ref_clk_i);
    msr_i <= '0;
    #1;
    while (msr_o.done !== 1'b1 && n < 4) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    if (n >= 4) begin
      num_errors++;
      $display("[ERR] msr_done expected 1 seen timeout");
      wrap_up();
    end
    data = {msr_o.hi, msr_o.lo};
    flt = msr_o.gp_fault;
  endtask : msr_op

  task automatic wr_reg(input ars_pkg::ars_tgt_t t, input logic [2:0] s,
                        input ars_pkg::ars_size_t z, input logic [63:0] v);
    @(posedge ref_clk_i);
    wr_i <= '{wr: 1'b1, tgt: t, sel: s, size: z, sub: 2'h0, data: v};
    @(posedge ref_clk_i);
    wr_i.wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_regs(input logic [2:0] s);
    @(posedge ref_clk_i);
    rd_sel_i <= s;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask : rd_regs

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    num_errors = 0;
    total_checks = 0;
    rst_i = 1'b1;
    wr_i = '0;
    ip_load_i = 1'b0;
    ip_target_i = 32'h0000_0000;
    ip_wide_i = 1'b0;
    msr_i = '0;
    rd_sel_i = 3'h0;
    idx_tab = '{ars_pkg::IDX_MC_FAULT_ADDR_LOG, ars_pkg::IDX_MC_FAULT_KIND_LOG,
                ars_pkg::IDX_L1_CACHE_TEST_CTL, ars_pkg::IDX_EXT_FEATURE_CTL,
                ars_pkg::IDX_SYSCALL_TARGET, ars_pkg::IDX_WRITE_ALLOC_CTL,
                ars_pkg::IDX_UC_WC_RANGE_CTL, ars_pkg::IDX_POWER_MGMT_CTL,
                ars_pkg::IDX_CPU_STATE_VIEW, ars_pkg::IDX_PAGE_FLUSH_CTL,
                ars_pkg::IDX_L2_ARRAY_PORT};
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    check("flag_reset", {32'h0, flag_word_o}, {32'h0, ars_pkg::FLAG_RST});
    for (int i = 0; i < 11; i++) begin
      msr_op(1'b1, 1'b0, idx_tab[i], 64'h0, d, f);
      check("msr_reset", d, ars_pkg::MSR_RST);
    end
    $display("test reset_values done");

    // every bank register except the tally holds its own pattern; logs included
    for (int i = 0; i < 11; i++) begin
      msr_op(1'b0, 1'b1, idx_tab[i], {32'hA5A5_0000 | 32'(i), idx_tab[i]}, d, f);
      check("msr_wr_fault", {63'h0, f}, 64'h0);
    end
    msr_op(1'b0, 1'b1, 32'hC000_0084, 64'hFFFF_FFFF_FFFF_FFFF, d, f);
    check("unmapped_wr_fault", {63'h0, f}, 64'h1);
    for (int i = 0; i < 11; i++) begin
      msr_op(1'b1, 1'b0, idx_tab[i], 64'h0, d, f);
      check("msr_readback", d, {32'hA5A5_0000 | 32'(i), idx_tab[i]});
    end
    $display("test msr_bank done");

    foreach (idx_tab[i]) begin
      msr_op(1'b1, 1'b0, idx_tab[i] + 32'h0000_0100, 64'h0, d, f);
      check("unmapped_rd_fault", {63'h0, f}, 64'h1);
      check("unmapped_rd_data", d, 64'h0);
    end
    $display("test unmapped done");

    // tally carries across the 32-bit halves
    msr_op(1'b0, 1'b1, ars_pkg::IDX_CYCLE_TALLY, 64'h0000_0000_FFFF_FFFF, d, f);
    msr_op(1'b1, 1'b0, ars_pkg::IDX_CYCLE_TALLY, 64'h0, d, f);
    check("tally_hi", {32'h0, d[63:32]}, 64'h1);
    check("tally_lo_small", {63'h0, d[31:0] < 32'h0000_0008}, 64'h1);
    // back-to-back reads one edge apart differ by exactly one
    @(posedge ref_clk_i);
    msr_i <= '{rd: 1'b1, wr: 1'b0, index: ars_pkg::IDX_CYCLE_TALLY, lo: 32'h0, hi: 32'h0};
    @(posedge ref_clk_i);
    #1;
    if (msr_o.done === 1'b1) tq.push_back({msr_o.hi, msr_o.lo});
    @(posedge ref_clk_i);
    msr_i <= '0;
    for (int k = 0; k < 4; k++) begin
      #1;
      if (msr_o.done === 1'b1) tq.push_back({msr_o.hi, msr_o.lo});
      @(posedge ref_clk_i);
    end
    check("tally_reads", 64'(tq.size()), 64'h2);
    if (tq.size() == 2) check("tally_step", tq[1] - tq[0], ars_pkg::TALLY_STEP);
    $display("test tally done");

    // enable bit set, still no exception
    wr_reg(ars_pkg::ARS_TGT_CR, 3'h4, ars_pkg::ARS_SZ_DWORD, 64'h0000_0000_0000_0040);
    wr_reg(ars_pkg::ARS_TGT_CR, 3'h0, ars_pkg::ARS_SZ_DWORD, 64'h0000_0000_0000_0001);
    repeat (3) @(posedge ref_clk_i);
    #1;
    check("mc_exception", {63'h0, mc_exception_o}, 64'h0);
    check("protected_mode", {63'h0, protected_mode_o}, 64'h1);
    wr_reg(ars_pkg::ARS_TGT_FLAG, 3'h0, ars_pkg::ARS_SZ_DWORD, 64'hFFFF_FFFF_FFFF_FFFF);
    repeat (2) @(posedge ref_clk_i);
    #1;
    check("flag_mask", {32'h0, flag_word_o},
          {32'h0, ars_pkg::FLAG_WR_MASK | ars_pkg::FLAG_RST});
    $display("test control done");

    wr_reg(ars_pkg::ARS_TGT_GPR, 3'h2, ars_pkg::ARS_SZ_DWORD, 64'h0000_0000_1122_3344);
    wr_reg(ars_pkg::ARS_TGT_GPR, 3'h2, ars_pkg::ARS_SZ_BYTE_HI, 64'h0000_0000_0000_00AA);
    rd_regs(3'h2);
    check("gpr_byte_hi", {32'h0, gpr_rd_o}, 64'h0000_0000_1122_AA44);
    wr_reg(ars_pkg::ARS_TGT_GPR, 3'h2, ars_pkg::ARS_SZ_BYTE_LO, 64'h0000_0000_0000_0055);
    rd_regs(3'h2);
    check("gpr_byte_lo", {32'h0, gpr_rd_o}, 64'h0000_0000_1122_AA55);
    wr_reg(ars_pkg::ARS_TGT_GPR, 3'h2, ars_pkg::ARS_SZ_WORD, 64'h0000_0000_0000_BEEF);
    rd_regs(3'h2);
    check("gpr_word", {32'h0, gpr_rd_o}, 64'h0000_0000_1122_BEEF);
    wr_reg(ars_pkg::ARS_TGT_GPR, 3'h7, ars_pkg::ARS_SZ_QWORD, 64'hCAFE_0001_DEAD_0007);
    rd_regs(3'h7);
    check("gpr_qword_lo", {32'h0, gpr_rd_o}, 64'h0000_0000_DEAD_0007);
    rd_regs(3'h0);
    check("gpr_qword_hi", {32'h0, gpr_rd_o}, 64'h0000_0000_CAFE_0001);
    wr_reg(ars_pkg::ARS_TGT_SEG, 3'h5, ars_pkg::ARS_SZ_WORD, 64'h0000_0000_0000_1234);
    wr_reg(ars_pkg::ARS_TGT_FP, 3'h5, ars_pkg::ARS_SZ_QWORD, 64'h3F80_0000_4000_0000);
    wr_reg(ars_pkg::ARS_TGT_FPW, 3'h0, ars_pkg::ARS_SZ_WORD, 64'h0000_0000_0000_4321);
    rd_regs(3'h5);
    check("seg_sel5", {48'h0, seg_rd_o}, 64'h0000_0000_0000_1234);
    check("simd_alias", simd_rd_o, 64'h3F80_0000_4000_0000);
    rd_regs(3'h6);
    check("seg_sel6", {48'h0, seg_rd_o}, 64'h0);
    $display("test reg_files done");

    @(posedge ref_clk_i);
    ip_load_i <= 1'b1;
    ip_target_i <= 32'h1234_5678;
    ip_wide_i <= 1'b0;
    @(posedge ref_clk_i);
    ip_load_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    check("ip_narrow", {32'h0, instr_pointer_wide_o}, 64'h0000_0000_0000_5678);
    @(posedge ref_clk_i);
    ip_load_i <= 1'b1;
    ip_wide_i <= 1'b1;
    @(posedge ref_clk_i);
    ip_load_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    check("ip_wide", {32'h0, instr_pointer_wide_o}, 64'h0000_0000_1234_5678);
    $display("test pointer done");

    do_reset();
    #1;
    msr_op(1'b1, 1'b0, ars_pkg::IDX_MC_FAULT_ADDR_LOG, 64'h0, d, f);
    check("addr_log_rereset", d, 64'h0);
    msr_op(1'b1, 1'b0, ars_pkg::IDX_MC_FAULT_KIND_LOG, 64'h0, d, f);
    check("kind_log_rereset", d, 64'h0);
    $display("test second_reset done");
    wrap_up();
  end

endmodule : testbench
